// ===== src/crs_regs.sv
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module crs_regs (
   input wire logic mclk,
   input wire logic rst_n,
   input wire crs_pkg::crs_cmd_t cmd,
   input wire logic cmd_valid,
   input wire logic fetch_step,
   input wire logic insn_done,
   input wire logic [crs_pkg::N_IRQ-1:0] irq_req,
   input wire logic brk_en,
   input wire logic brk_req,
   input wire logic monitor_mode,
   input wire logic stop_enable,
   input wire logic short_stop_recovery,
   output crs_pkg::crs_mem_t mem,
   input wire logic mem_ack,
   input wire logic [7:0] mem_rdata,
   output logic busy,
   output logic cpu_clk_en,
   output logic illegal_op,
   output logic [15:0] eff_addr,
   output logic [7:0] acc_out,
   output logic [7:0] ccr_out,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import crs_pkg::*;

   logic [7:0] working_accumulator_q;
   logic [15:0] index_pair_q;
   logic [15:0] stack_pointer_q;
   logic [15:0] program_counter_q;
   logic [7:0] condition_code_reg_q;
   crs_state_t state_q;
   logic [2:0] step_q;
   logic [15:0] vec_q;
   logic [12:0] recov_q;
   logic [15:0] eff_addr_q;
   logic illegal_q;
   logic [7:0] alu_res;
   logic [7:0] alu_cc;
   logic run_cmd;
   logic boundary;
   logic irq_any;
   logic take_brk;
   logic take_irq;
   logic take_swi;
   logic [15:0] irq_vec;
   logic br_taken;
   logic apb_wr;
   logic [2:0] apb_sel;
   logic mapped;
   logic mem_done;

   // one flag helper: keeps n/z rule in one place
   function automatic logic [7:0] nz(input logic [7:0] cc, input logic [7:0] r);
      logic [7:0] o;
      o = cc;
      o[CC_N] = r[7]; // RL19
      o[CC_Z] = (r == 8'h00); // RL20
      return o;
   endfunction

   function automatic logic [15:0] sext(input logic [15:0] d, input crs_alu_t a);
      // 8-bit displacements come in the low byte; a = ALU_ADD marks 16-bit ones
      return (a == ALU_ADD) ? d : {{8{d[7]}}, d[7:0]};
   endfunction

   assign run_cmd = cmd_valid && (state_q == ST_RUN);
   assign boundary = insn_done && (state_q == ST_RUN);
   assign irq_any = |irq_req;
   assign take_brk = boundary && brk_en && brk_req; // RL24
   assign take_irq = boundary && !take_brk && irq_any && !condition_code_reg_q[CC_I]; // RL13
   assign take_swi = run_cmd && (cmd.op == OP_SWI) && !boundary;
   assign mem_done = mem.req && mem_ack;

   // lowest index is highest priority
   always_comb begin
      irq_vec = VEC_IRQ_TOP;
      for (int i = N_IRQ - 1; i >= 0; i--) begin
         if (irq_req[i]) begin
            irq_vec = VEC_IRQ_TOP - TWO16 * 16'(i); // RL16
         end
      end
   end

   // arithmetic unit: result and updated flags
   always_comb begin
      logic [8:0] s;
      logic [4:0] lo;
      logic [7:0] a;
      logic [7:0] m;
      logic cin;
      s = 9'h000;
      lo = 5'h00;
      a = working_accumulator_q;
      m = cmd.data[7:0];
      cin = condition_code_reg_q[CC_C];
      alu_res = a;
      alu_cc = condition_code_reg_q; // RL26
      unique case (cmd.alu)
         ALU_ADD, ALU_ADC: begin
            s = {1'b0, a} + {1'b0, m} + {8'h00, (cmd.alu == ALU_ADC) & cin};
            lo = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, (cmd.alu == ALU_ADC) & cin};
            alu_res = s[7:0];
            alu_cc = nz(condition_code_reg_q, s[7:0]);
            alu_cc[CC_H] = lo[4]; // RL12
            alu_cc[CC_C] = s[8]; // RL21
            alu_cc[CC_V] = (a[7] == m[7]) && (s[7] != a[7]); // RL11
         end
         ALU_SUB, ALU_SBC: begin
            s = {1'b0, a} - {1'b0, m} - {8'h00, (cmd.alu == ALU_SBC) & cin};
            alu_res = s[7:0];
            alu_cc = nz(condition_code_reg_q, s[7:0]);
            alu_cc[CC_C] = s[8]; // RL21
            alu_cc[CC_V] = (a[7] != m[7]) && (s[7] != a[7]); // RL11
         end
         ALU_AND, ALU_ORA, ALU_EOR: begin
            alu_res = (cmd.alu == ALU_AND) ? (a & m) : (cmd.alu == ALU_ORA) ? (a | m) : (a ^ m);
            alu_cc = nz(condition_code_reg_q, alu_res);
            alu_cc[CC_V] = 1'b0;
         end
         ALU_LSL, ALU_ROL: begin
            alu_res = {a[6:0], (cmd.alu == ALU_ROL) & cin};
            alu_cc = nz(condition_code_reg_q, alu_res);
            alu_cc[CC_C] = a[7]; // RL21
            alu_cc[CC_V] = alu_res[7] ^ a[7];
         end
         ALU_LSR, ALU_ROR, ALU_ASR: begin
            alu_res = {(cmd.alu == ALU_ASR) ? a[7] : (cmd.alu == ALU_ROR) & cin, a[7:1]};
            alu_cc = nz(condition_code_reg_q, alu_res);
            alu_cc[CC_C] = a[0]; // RL21
            alu_cc[CC_V] = alu_res[7] ^ a[0];
         end
         ALU_BTST: begin
            alu_cc[CC_C] = cmd.data[8]; // RL21
         end
         default: begin
            alu_res = a;
         end
      endcase
   end

   // branch condition, signed forms use the overflow flag
   always_comb begin
      logic n;
      logic v;
      logic z;
      n = condition_code_reg_q[CC_N];
      v = condition_code_reg_q[CC_V];
      z = condition_code_reg_q[CC_Z];
      unique case (cmd.cond)
         BR_ALWAYS: br_taken = 1'b1;
         BR_GT: br_taken = !z && (n == v); // RL11
         BR_GE: br_taken = (n == v);
         BR_LE: br_taken = z || (n != v);
         BR_LT: br_taken = (n != v);
         BR_EQ: br_taken = z;
         BR_CC: br_taken = !condition_code_reg_q[CC_C];
         BR_CS: br_taken = condition_code_reg_q[CC_C];
      endcase
   end

   // memory/stack requests
   always_comb begin
      mem = '0;
      unique case (state_q)
         ST_RSTV_H, ST_RSTV_L, ST_VEC_H, ST_VEC_L: begin
            mem.req = 1'b1;
            mem.addr = vec_q + ((state_q == ST_RSTV_L || state_q == ST_VEC_L) ? ONE16 : 16'h0000);
         end
         ST_PUSH, ST_PUSH_INDEX_HIGH_OP: begin
            mem.req = 1'b1;
            mem.we = 1'b1;
            mem.addr = stack_pointer_q;
            if (state_q == ST_PUSH_INDEX_HIGH_OP) begin
               mem.wdata = index_pair_q[15:8];
            end else begin
               unique case (step_q)
                  3'h0: mem.wdata = program_counter_q[7:0];
                  3'h1: mem.wdata = program_counter_q[15:8];
                  3'h2: mem.wdata = index_pair_q[7:0]; // RL15
                  3'h3: mem.wdata = working_accumulator_q;
                  default: mem.wdata = condition_code_reg_q | CC_FIXED_ONES;
               endcase
            end
         end
         ST_PULL, ST_PULL_INDEX_HIGH_OP: begin
            mem.req = 1'b1;
            mem.addr = stack_pointer_q + ONE16;
         end
         default: begin
            mem.req = 1'b0;
         end
      endcase
   end

   // sequencer
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_q <= ST_RSTV_H; // RL9
         step_q <= 3'h0;
         vec_q <= VEC_RESET_HI;
         recov_q <= 13'h0000;
         illegal_q <= 1'b0;
      end else begin
         illegal_q <= 1'b0;
         unique case (state_q)
            ST_RSTV_H: if (mem_done) state_q <= ST_RSTV_L;
            ST_RSTV_L: if (mem_done) state_q <= ST_RUN;
            ST_RUN: begin
               step_q <= 3'h0;
               if (take_brk) begin
                  vec_q <= monitor_mode ? VEC_BREAK_MON : VEC_BREAK; // RL24
                  state_q <= ST_PUSH;
               end else if (take_irq) begin
                  vec_q <= irq_vec; // RL16
                  state_q <= ST_PUSH;
               end else if (take_swi) begin
                  vec_q <= monitor_mode ? VEC_BREAK_MON : VEC_BREAK;
                  state_q <= ST_PUSH;
               end else if (run_cmd) begin
                  if (cmd.op == OP_WAIT) begin
                     state_q <= ST_WAIT; // RL22
                  end else if (cmd.op == OP_STOP) begin
                     if (stop_enable) begin
                        state_q <= ST_STOP; // RL23
                     end else begin
                        illegal_q <= 1'b1; // RL25
                     end
                  end else if (cmd.op == OP_ALU && cmd.alu == ALU_RTI) begin
                     state_q <= ST_PULL; // RL17
                  end else if (cmd.op == OP_ALU && cmd.alu == ALU_PUSH_INDEX_HIGH_OP) begin
                     state_q <= ST_PUSH_INDEX_HIGH_OP;
                  end else if (cmd.op == OP_ALU && cmd.alu == ALU_PULL_INDEX_HIGH_OP) begin
                     state_q <= ST_PULL_INDEX_HIGH_OP;
                  end
               end
            end
            ST_PUSH: begin
               if (mem_done) begin
                  step_q <= step_q + 3'h1;
                  if (step_q == STACK_LAST) begin
                     state_q <= ST_VEC_H; // RL14
                  end
               end
            end
            ST_VEC_H: if (mem_done) state_q <= ST_VEC_L;
            ST_VEC_L: if (mem_done) state_q <= ST_RUN;
            ST_PULL: begin
               if (mem_done) begin
                  step_q <= step_q + 3'h1;
                  if (step_q == STACK_LAST) begin
                     state_q <= ST_RUN;
                  end
               end
            end
            ST_PUSH_INDEX_HIGH_OP, ST_PULL_INDEX_HIGH_OP: if (mem_done) state_q <= ST_RUN;
            ST_WAIT: begin
               if (irq_any) begin
                  vec_q <= irq_vec; // RL22
                  step_q <= 3'h0;
                  state_q <= ST_PUSH;
               end
            end
            ST_STOP: begin
               if (irq_any) begin
                  vec_q <= irq_vec;
                  recov_q <= short_stop_recovery ? STOP_SHORT_CYC : STOP_LONG_CYC;
                  state_q <= ST_RECOV;
               end
            end
            ST_RECOV: begin
               recov_q <= recov_q - 13'h0001;
               if (recov_q == 13'h0001) begin
                  step_q <= 3'h0;
                  state_q <= ST_PUSH; // RL23
               end
            end
            default: state_q <= ST_RSTV_H;
         endcase
      end
   end

   // accumulator
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         working_accumulator_q <= 8'h00;
      end else if (apb_wr && apb_sel == 3'h0) begin
         working_accumulator_q <= pwdata[7:0];
      end else if (state_q == ST_PULL && mem_done && step_q == 3'h1) begin
         working_accumulator_q <= mem_rdata; // RL17
      end else if (run_cmd && cmd.op == OP_ALU && cmd.alu <= ALU_ASR) begin
         working_accumulator_q <= alu_res; // RL1
      end else if (run_cmd && cmd.op == OP_LD_A) begin
         working_accumulator_q <= cmd.data[7:0];
         end
   end

   // index pair
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         index_pair_q <= 16'h0000;
      end else if (apb_wr && apb_sel == 3'h1) begin
         index_pair_q <= pwdata[15:0];
      end else if (state_q == ST_PULL && mem_done && step_q == 3'h2) begin
         index_pair_q[7:0] <= mem_rdata; // RL15
      end else if (state_q == ST_PULL_INDEX_HIGH_OP && mem_done) begin
         index_pair_q[15:8] <= mem_rdata;
      end else if (run_cmd && cmd.op == OP_LD_HX) begin
         index_pair_q <= cmd.data; // RL2
      end else if (run_cmd && cmd.op == OP_LD_H) begin
         index_pair_q[15:8] <= cmd.data[7:0]; // RL2
      end else if (run_cmd && cmd.op == OP_LD_X) begin
         index_pair_q[7:0] <= cmd.data[7:0]; // RL2
      end
   end

   // stack pointer
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         stack_pointer_q <= SP_RESET; // RL4
      end else if (apb_wr && apb_sel == 3'h2) begin
         stack_pointer_q <= pwdata[15:0];
      end else if ((state_q == ST_PUSH || state_q == ST_PUSH_INDEX_HIGH_OP) && mem_done) begin
         stack_pointer_q <= stack_pointer_q - ONE16; // RL6
      end else if ((state_q == ST_PULL || state_q == ST_PULL_INDEX_HIGH_OP) && mem_done) begin
         stack_pointer_q <= stack_pointer_q + ONE16; // RL6
      end else if (run_cmd && cmd.op == OP_RSP) begin
         stack_pointer_q[7:0] <= SP_LOW_RESET; // RL5
      end else if (run_cmd && cmd.op == OP_LD_SP) begin
         stack_pointer_q <= cmd.data;
      end
   end

   // program counter
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         program_counter_q <= 16'h0000;
      end else if ((state_q == ST_RSTV_H || state_q == ST_VEC_H) && mem_done) begin
         program_counter_q[15:8] <= mem_rdata; // RL9
      end else if ((state_q == ST_RSTV_L || state_q == ST_VEC_L) && mem_done) begin
         program_counter_q[7:0] <= mem_rdata; // RL9
      end else if (state_q == ST_PULL && mem_done && step_q == 3'h3) begin
         program_counter_q[15:8] <= mem_rdata;
      end else if (state_q == ST_PULL && mem_done && step_q == STACK_LAST) begin
         program_counter_q[7:0] <= mem_rdata;
      end else if (apb_wr && apb_sel == 3'h3) begin
         program_counter_q <= pwdata[15:0];
      end else if (run_cmd && cmd.op == OP_JUMP) begin
         program_counter_q <= cmd.data; // RL8
      end else if (run_cmd && cmd.op == OP_BRANCH && br_taken) begin
         program_counter_q <= program_counter_q + sext(cmd.data, ALU_LSL); // RL8
      end else if (fetch_step && state_q == ST_RUN) begin
         program_counter_q <= program_counter_q + ONE16; // RL8
      end
   end

   // condition codes
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         condition_code_reg_q <= CC_RESET; // RL18
      end else if (state_q == ST_PUSH && mem_done && step_q == STACK_LAST) begin
         condition_code_reg_q[CC_I] <= 1'b1; // RL14
      end else if (state_q == ST_PULL && mem_done && step_q == 3'h0) begin
         condition_code_reg_q <= mem_rdata | CC_FIXED_ONES; // RL17
      end else if (apb_wr && apb_sel == 3'h4) begin
         condition_code_reg_q <= (pwdata[7:0] & ~(8'h01 << CC_I))
            | (condition_code_reg_q & (8'h01 << CC_I)) | CC_FIXED_ONES; // RL18
      end else if (run_cmd) begin
         unique case (cmd.op)
            OP_ALU: condition_code_reg_q <= alu_cc | CC_FIXED_ONES; // RL26
            OP_CLI, OP_WAIT: condition_code_reg_q[CC_I] <= 1'b0; // RL18
            OP_STOP: if (stop_enable) condition_code_reg_q[CC_I] <= 1'b0; // RL23
            OP_SEI: condition_code_reg_q[CC_I] <= 1'b1;
            OP_LD_CCR: condition_code_reg_q <= cmd.data[7:0] | CC_FIXED_ONES; // RL10
            default: condition_code_reg_q <= condition_code_reg_q;
         endcase
      end
   end

   // effective address for indexed and stack-relative operands
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         eff_addr_q <= 16'h0000;
      end else if (run_cmd && cmd.mode == EA_INDEX) begin
         eff_addr_q <= index_pair_q + sext(cmd.data, cmd.alu); // RL3
      end else if (run_cmd && cmd.mode == EA_SP) begin
         eff_addr_q <= stack_pointer_q + sext(cmd.data, cmd.alu); // RL7
      end
   end

   // apb slave, zero wait states
   assign apb_sel = paddr[4:2];
   assign mapped = (paddr[1:0] == 2'b00) && (paddr <= ADDR_STATUS);
   assign apb_wr = psel && penable && pwrite && mapped;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   always_comb begin
      prdata = 32'h0000_0000;
      if (psel && mapped) begin
         unique case (paddr)
            ADDR_ACC: prdata[7:0] = working_accumulator_q;
            ADDR_INDEX: prdata[15:0] = index_pair_q;
            ADDR_STACK: prdata[15:0] = stack_pointer_q;
            ADDR_PC: prdata[15:0] = program_counter_q;
            ADDR_CCR: prdata[7:0] = condition_code_reg_q | CC_FIXED_ONES; // RL10
            ADDR_STATUS: prdata[5:0] = {cpu_clk_en, busy, state_q};
            default: prdata = 32'h0000_0000;
         endcase
      end
   end

   assign busy = (state_q != ST_RUN);
   assign cpu_clk_en = !(state_q == ST_WAIT || state_q == ST_STOP || state_q == ST_RECOV);
   assign illegal_op = illegal_q;
   assign eff_addr = eff_addr_q;
   assign acc_out = working_accumulator_q;
   assign ccr_out = condition_code_reg_q | CC_FIXED_ONES;
endmodule
`default_nettype wire

// ===== src/crs_pkg.sv
// Behaviour
// RL1 - one 8-bit working accumulator feeds the arithmetic unit and takes its results
// RL2 - 16-bit index pair built from upper and lower byte, also plain storage
// RL3 - indexed modes form the effective address from the index pair
// RL4 - every reset loads the stack pointer with 0x00FF
// RL5 - reset-stack op forces stack pointer low byte to 0xFF, high byte kept
// RL6 - stack pointer decrements per pushed byte, increments per pulled byte
// RL7 - stack-relative modes add 8- or 16-bit displacement to the stack pointer
// RL8 - program counter steps after each fetch; jumps, taken branches, interrupts load it
// RL9 - reset loads program counter from the top reset vector pair, high byte first
// RL10 - condition code bits 6 and 5 always read as one
// RL11 - overflow flag set on two's complement overflow; signed branches test it
// RL12 - add and add-with-carry set half-carry on carry from bit 3 into 4
// RL13 - maskable requests ignored while the mask is set
// RL14 - interrupt entry stacks registers, then sets the mask, then fetches the vector
// RL15 - upper index byte is not stacked on interrupt entry
// RL16 - after the mask clears the highest-priority pending request goes first
// RL17 - return-from-interrupt restores stacked registers including the mask
// RL18 - reset sets the mask; only the clear-mask op clears it by software; here the wait, stop and load-ccr ops also clear it
// RL19 - negative flag equals bit 7 of the result
// RL20 - zero flag set exactly when the result is all zeros
// RL21 - carry on add carry-out or subtract borrow; shifts, rotates, bit-test also set it
// RL22 - wait clears mask, stops cpu clock; interrupt wake keeps mask clear, reset sets it
// RL23 - stop clears mask, stops clock, restarts after stabilisation delay; reset sets mask
// RL24 - enabled break request forces a software interrupt at instruction end via break vector
// RL25 - with stop disabled the stop op is flagged as an illegal opcode
// RL26 - flags an operation does not define keep their previous values
package crs_pkg;
   localparam int unsigned N_IRQ = 4;
   localparam logic [15:0] SP_RESET = 16'h00FF;
   localparam logic [7:0] SP_LOW_RESET = 8'hFF;
   localparam logic [15:0] VEC_RESET_HI = 16'hFFFE;
   localparam logic [15:0] VEC_BREAK = 16'hFFFC;
   localparam logic [15:0] VEC_BREAK_MON = 16'hFEFC;
   localparam logic [15:0] VEC_IRQ_TOP = 16'hFFFA;
   localparam logic [15:0] ONE16 = 16'h0001;
   localparam logic [15:0] TWO16 = 16'h0002;
   // condition code field positions
   localparam int unsigned CC_C = 0;
   localparam int unsigned CC_Z = 1;
   localparam int unsigned CC_N = 2;
   localparam int unsigned CC_I = 3;
   localparam int unsigned CC_H = 4;
   localparam int unsigned CC_V = 7;
   localparam logic [7:0] CC_FIXED_ONES = 8'h60;
   localparam logic [7:0] CC_RESET = 8'h68;
   // stop recovery in cycles
   localparam logic [12:0] STOP_LONG_CYC = 13'h1000;
   localparam logic [12:0] STOP_SHORT_CYC = 13'h0020;
   localparam logic [2:0] STACK_LAST = 3'h4;
   // apb byte addresses
   localparam logic [7:0] ADDR_ACC = 8'h00;
   localparam logic [7:0] ADDR_INDEX = 8'h04;
   localparam logic [7:0] ADDR_STACK = 8'h08;
   localparam logic [7:0] ADDR_PC = 8'h0C;
   localparam logic [7:0] ADDR_CCR = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;

   typedef enum logic [3:0] {
      OP_NOP, OP_ALU, OP_LD_A, OP_LD_HX, OP_LD_H, OP_LD_X, OP_LD_SP, OP_JUMP,
      OP_BRANCH, OP_RSP, OP_CLI, OP_SEI, OP_LD_CCR, OP_SWI, OP_WAIT, OP_STOP
   } crs_op_t;
   typedef enum logic [3:0] {
      ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_ORA, ALU_EOR, ALU_LSL,
      ALU_LSR, ALU_ROL, ALU_ROR, ALU_ASR, ALU_PUSH_INDEX_HIGH_OP, ALU_PULL_INDEX_HIGH_OP, ALU_RTI, ALU_BTST
   } crs_alu_t;
   typedef enum logic [2:0] {
      BR_ALWAYS, BR_GT, BR_GE, BR_LE, BR_LT, BR_EQ, BR_CC, BR_CS
   } crs_cond_t;
   typedef enum logic [1:0] {
      EA_NONE, EA_INDEX, EA_SP
   } crs_mode_t;
   typedef enum logic [3:0] {
      ST_RSTV_H = 4'b0000, ST_RSTV_L = 4'b0001, ST_RUN = 4'b0011, ST_PUSH = 4'b0010,
      ST_VEC_H = 4'b0110, ST_VEC_L = 4'b0111, ST_PULL = 4'b0101, ST_WAIT = 4'b0100,
      ST_STOP = 4'b1100, ST_RECOV = 4'b1101, ST_PUSH_INDEX_HIGH_OP = 4'b1111, ST_PULL_INDEX_HIGH_OP = 4'b1110
   } crs_state_t;

   typedef struct packed {
      crs_op_t op;
      crs_alu_t alu;
      crs_cond_t cond;
      crs_mode_t mode;
      logic [15:0] data;
   } crs_cmd_t;
   typedef struct packed {
      logic req;
      logic we;
      logic [15:0] addr;
      logic [7:0] wdata;
   } crs_mem_t;
endpackage

// ===== test/crs_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module crs_mem_model (
   input wire logic mclk,
   input wire crs_pkg::crs_mem_t mem,
   input wire logic slow,
   output logic mem_ack,
   output logic [7:0] mem_rdata
);
   import crs_pkg::*;
   logic [7:0] ram [logic [15:0]];
   logic [1:0] wait_q = 2'h0;
   // slow: two stall cycles per request
   always @(posedge mclk) begin
      if (!mem.req || mem_ack) wait_q <= slow ? 2'h2 : 2'h0;
      else if (wait_q != 2'h0) wait_q <= wait_q - 2'h1;
      if (mem.req && mem.we && mem_ack) ram[mem.addr] = mem.wdata;
   end
   assign mem_ack = mem.req && wait_q == 2'h0;
   // unwritten bytes read addr^5A; junk off ack
   assign mem_rdata = !mem_ack ? ~mem.addr[7:0] :
      ram.exists(mem.addr) ? ram[mem.addr] : mem.addr[7:0] ^ 8'h5A;
endmodule
`default_nettype wire

// ===== test/crs_regs_properties.sv
`timescale 1ns/1ns
`default_nettype none
module crs_regs_properties (
   input wire logic mclk,
   input wire logic rst_n,
   input wire crs_pkg::crs_cmd_t cmd,
   input wire logic cmd_valid,
   input wire logic stop_enable,
   input wire crs_pkg::crs_mem_t mem,
   input wire logic mem_ack,
   input wire logic busy,
   input wire logic cpu_clk_en,
   input wire logic illegal_op,
   input wire logic [7:0] acc_out,
   input wire logic [7:0] ccr_out
);
   import crs_pkg::*;
   logic tk;
   assign tk = cmd_valid && !busy;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   property p_fix; ccr_out[6:5] == 2'b11; endproperty
   a_fix: assert property (p_fix) else $error("ccr fixed bits low");
   property p_rst; $rose(rst_n) |-> ccr_out[CC_I] && mem.req && mem.addr == VEC_RESET_HI;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   property p_cli; tk && cmd.op == OP_CLI |=> !ccr_out[CC_I]; endproperty
   a_cli: assert property (p_cli) else $error("mask not cleared");
   property p_nz; tk && cmd.op == OP_ALU && cmd.alu == ALU_AND
      |=> ccr_out[CC_N] == acc_out[7] && ccr_out[CC_Z] == (acc_out == 8'h00); endproperty
   a_nz: assert property (p_nz) else $error("n or z wrong");
   property p_ill; tk && cmd.op == OP_STOP && !stop_enable |=> illegal_op ##1 !illegal_op;
   endproperty
   a_ill: assert property (p_ill) else $error("illegal pulse wrong");
   property p_stop; tk && cmd.op == OP_STOP && stop_enable |=> !cpu_clk_en && !ccr_out[CC_I];
   endproperty
   a_stop: assert property (p_stop) else $error("stop entry wrong");
   property p_wait; tk && cmd.op == OP_WAIT |=> busy && !cpu_clk_en && !ccr_out[CC_I];
   endproperty
   a_wait: assert property (p_wait) else $error("wait entry wrong");
   property p_push; mem.req && mem.we && mem_ack ##1 mem.req && mem.we
      |-> mem.addr == $past(mem.addr) - ONE16; endproperty
   a_push: assert property (p_push) else $error("push address wrong");
   c_push: cover property (mem.req && mem.we && mem_ack);
   c_wake: cover property ($rose(cpu_clk_en));
   c_ill: cover property (illegal_op);
endmodule
bind crs_regs crs_regs_properties u_props (.*);
`default_nettype wire

// ===== test/cpu_register_set_and_flags_tb.sv
`timescale 1ns/1ns
`default_nettype none
module cpu_register_set_and_flags_tb;
   import crs_pkg::*;
   logic mclk = 0, rst_n = 0, cmd_valid = 0, fetch_step = 0, insn_done = 0, brk_en = 0;
   logic brk_req = 0, monitor_mode = 0, stop_enable = 0, short_stop_recovery = 0, slow = 0;
   logic psel = 0, penable = 0, pwrite = 0, mem_ack, busy, cpu_clk_en, illegal_op, pready;
   logic pslverr, perr;
   logic [N_IRQ-1:0] irq_req = 0;
   logic [7:0] paddr = 0, mem_rdata, acc_out, ccr_out;
   logic [15:0] eff_addr;
   logic [31:0] pwdata = 0, prdata, r;
   crs_cmd_t cmd = '0;
   crs_mem_t mem;
   int errors = 0, check_count = 0;
   always #5 mclk = ~mclk;
   crs_regs u_dut (.*);
   crs_mem_model u_mem (.*);
   task automatic report_and_stop();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      for (int k = 0; k < 20; k++) begin
         @(posedge mclk);
         if (pready === 1'b1) break;
      end
      r = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) errors++;
      if (pready !== 1'b1) report_and_stop();
      @(posedge mclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), r, e);
   endtask
   task automatic op(input crs_op_t o, input crs_alu_t a, input crs_mode_t m, input logic [15:0] d);
      cmd <= '{o, a, BR_ALWAYS, m, d};
      cmd_valid <= 1'b1;
      @(posedge mclk);
      cmd_valid <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic boundary();
      insn_done <= 1'b1;
      @(posedge mclk);
      insn_done <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic idle();
      for (int k = 0; k < 9000 && busy !== 1'b0; k++) @(posedge mclk);
      if (busy !== 1'b0) errors++;
      if (busy !== 1'b0) report_and_stop();
   endtask
   task automatic t_reset();
      idle();
      rd(ADDR_PC, 32'hA4A5);
      rd(ADDR_STACK, 32'hFF);
      apb(1'b1, ADDR_CCR, 32'h0);
      rd(ADDR_CCR, 32'h68);
      rd(8'h18, 32'h0);
      chk("pslverr", perr, 1'b1);
   endtask
   task automatic t_alu();
      op(OP_LD_A, ALU_ADD, EA_NONE, 16'h7F);
      op(OP_ALU, ALU_ADD, EA_NONE, 16'h01);
      chk("acc ccr", {acc_out, ccr_out}, 16'h80FC);
      op(OP_ALU, ALU_ADD, EA_NONE, 16'h80);
      chk("acc ccr", {acc_out, ccr_out}, 16'h00EB);
      op(OP_ALU, ALU_SUB, EA_NONE, 16'h01);
      chk("acc ccr", {acc_out, ccr_out}, 16'hFF6D);
      op(OP_ALU, ALU_AND, EA_NONE, 16'h0F);
      chk("acc ccr", {acc_out, ccr_out}, 16'h0F69);
   endtask
   task automatic t_addr();
      apb(1'b1, ADDR_STACK, 32'h1234);
      op(OP_RSP, ALU_ADD, EA_NONE, 16'h0);
      rd(ADDR_STACK, 32'h12FF);
      op(OP_NOP, ALU_ADD, EA_SP, 16'h0010);
      chk("eff_addr", eff_addr, 16'h130F);
      op(OP_NOP, ALU_AND, EA_SP, 16'h00F0);
      chk("eff_addr", eff_addr, 16'h12EF);
      apb(1'b1, ADDR_INDEX, 32'hABCD);
      op(OP_NOP, ALU_ADD, EA_INDEX, 16'h0003);
      chk("eff_addr", eff_addr, 16'hABD0);
      apb(1'b1, ADDR_PC, 32'h2000);
      fetch_step <= 1'b1;
      @(posedge mclk);
      fetch_step <= 1'b0;
      rd(ADDR_PC, 32'h2001);
      op(OP_BRANCH, ALU_ADD, EA_NONE, 16'h00FE);
      rd(ADDR_PC, 32'h1FFF);
   endtask
   task automatic t_irq();
      slow <= 1'b1;
      apb(1'b1, ADDR_STACK, 32'hFF);
      irq_req <= 4'h6;
      boundary();
      chk("busy", busy, 1'b0);
      op(OP_CLI, ALU_ADD, EA_NONE, 16'h0);
      boundary();
      idle();
      irq_req <= 4'h0;
      chk("mask", ccr_out[CC_I], 1'b1);
      rd(ADDR_PC, 32'hA2A3);
      rd(ADDR_STACK, 32'hFA);
      op(OP_ALU, ALU_RTI, EA_NONE, 16'h0);
      idle();
      rd(ADDR_STACK, 32'hFF);
      rd(ADDR_PC, 32'h1FFF);
      chk("mask", ccr_out[CC_I], 1'b0);
   endtask
   task automatic t_low();
      op(OP_STOP, ALU_ADD, EA_NONE, 16'h0);
      chk("busy", busy, 1'b0);
      op(OP_WAIT, ALU_ADD, EA_NONE, 16'h0);
      rd(ADDR_STATUS, 32'h14);
      irq_req <= 4'h2;
      idle();
      irq_req <= 4'h0;
      rd(ADDR_PC, 32'hA2A3);
      stop_enable <= 1'b1;
      short_stop_recovery <= 1'b1;
      op(OP_STOP, ALU_ADD, EA_NONE, 16'h0);
      rd(ADDR_STATUS, 32'h1C);
      irq_req <= 4'h2;
      idle();
      irq_req <= 4'h0;
      rd(ADDR_PC, 32'hA2A3);
      brk_en <= 1'b1;
      brk_req <= 1'b1;
      monitor_mode <= 1'b1;
      boundary();
      brk_req <= 1'b0;
      idle();
      rd(ADDR_PC, 32'hA6A7);
   endtask
   initial begin
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      t_reset();
      t_alu();
      t_addr();
      t_irq();
      t_low();
      report_and_stop();
   end
endmodule
`default_nettype wire
